/* hdl/amss_seq.sv */
// Asynchronous external memory strobe sequencer: setup, strobe, hold, turnaround.
// Assumes the requester holds its request stable until o_req_ready pulses.
`timescale 1ns/1ps
`default_nettype none
`include "amss_consts.svh"
module amss_seq (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_req_valid,
  input  wire logic               i_req_write,
  input  wire amss_pkg::amss_addr_t i_req_addr,
  input  wire amss_pkg::amss_bank_t i_req_bank,
  input  wire amss_pkg::amss_cs_t   i_req_cs_n,
  input  wire logic               i_extended_wait_enable,
  input  wire logic               i_select_strobe,
  input  wire amss_pkg::amss_cnt_t  i_turnaround_count,
  input  wire amss_pkg::amss_cnt_t  i_read_setup_count,
  input  wire amss_pkg::amss_cnt_t  i_read_strobe_count,
  input  wire amss_pkg::amss_cnt_t  i_read_hold_count,
  input  wire amss_pkg::amss_cnt_t  i_write_setup_count,
  input  wire amss_pkg::amss_cnt_t  i_write_strobe_count,
  input  wire amss_pkg::amss_cnt_t  i_write_hold_count,
  input  wire amss_pkg::amss_cnt_t  i_max_external_wait,
  input  wire logic               i_wait_request_in,
  output logic                    o_req_ready,
  output logic                    o_busy,
  output logic                    o_wait_timeout,
  output amss_pkg::amss_cnt_t     o_external_wait_units,
  output amss_pkg::amss_cs_t      o_async_chip_select_n,
  output logic                    o_output_enable_n,
  output logic                    o_write_enable_n,
  output amss_pkg::amss_addr_t    o_mem_address_out,
  output amss_pkg::amss_bank_t    o_bank_select_out
);
  import amss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // A zero count still gives its phase one cycle, so phases never vanish.
  function automatic amss_cnt_t amss_len(input amss_cnt_t n);
    amss_len = (n == `AMSS_CNT_RST) ? 8'h01 : n;
  endfunction

  amss_state_e state_ff, nxt_state;
  amss_cnt_t   cnt_ff, nxt_cnt;
  amss_cnt_t   units_ff, nxt_units;
  logic        write_ff;
  logic        timeout_ff, nxt_timeout;
  logic [2:0]  wsync_ff;
  amss_cs_t    cs_ff;
  amss_addr_t  addr_ff;
  amss_bank_t  bank_ff;
  logic        oe_n_ff, we_n_ff;

  // Wait pin is asynchronous: three stages, change counts when the last two agree.
  logic wait_seen_ff;
  wire  wait_agree = (wsync_ff[1] == wsync_ff[2]);
  wire  wait_now   = wait_agree ? wsync_ff[2] : wait_seen_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Setup, strobe and hold lengths selected by direction; turnaround length is shared.
  wire amss_cnt_t setup_len  = amss_len(write_ff ? i_write_setup_count : i_read_setup_count);
  wire amss_cnt_t strobe_len = amss_len(write_ff ? i_write_strobe_count : i_read_strobe_count);
  wire amss_cnt_t hold_len   = amss_len(write_ff ? i_write_hold_count : i_read_hold_count);
  wire amss_cnt_t turn_len   = amss_len(i_turnaround_count);
  wire            cnt_last   = (cnt_ff == 8'h01);
  wire            take       = (state_ff == AMSS_IDLE) && i_req_valid;
  wire            strobe_on  = (state_ff == AMSS_STRB) || (state_ff == AMSS_EXT) ||
                               (state_ff == AMSS_TAIL);
  wire            cs_on      = i_select_strobe ? strobe_on :
                               ((state_ff == AMSS_SETUP) || strobe_on ||
                                (state_ff == AMSS_HOLD));
  wire            units_full = (units_ff >= i_max_external_wait);

  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_units   = units_ff;
    nxt_timeout = timeout_ff;
    case (state_ff)
      AMSS_IDLE: begin
        if (i_req_valid) begin
          nxt_state   = AMSS_SETUP;
          nxt_cnt     = amss_len(i_req_write ? i_write_setup_count : i_read_setup_count);
          nxt_units   = `AMSS_CNT_RST;
          nxt_timeout = 1'b0;
        end
      end
      AMSS_SETUP: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_last) begin
          nxt_state = AMSS_STRB;
          nxt_cnt   = strobe_len;
        end
      end
      AMSS_STRB: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_last) begin
          if (i_extended_wait_enable && wait_now) begin
            nxt_state = AMSS_EXT;
            nxt_cnt   = `AMSS_WAIT_UNIT;
            nxt_units = 8'h01;
          end else begin
            nxt_state = AMSS_HOLD;
            nxt_cnt   = hold_len;
          end
        end
      end
      AMSS_EXT: begin
        // Whole units of sixteen; a released wait lets the strobe end four cycles on.
        // The synchroniser already used three of those four cycles, so the tail is short.
        nxt_cnt = cnt_ff - 8'h01;
        if (!wait_now) begin
          nxt_state = AMSS_TAIL;
          nxt_cnt   = {5'h00, `AMSS_WAIT_LEAD - `AMSS_SYNC_LAG};
        end else if (cnt_last) begin
          nxt_cnt = `AMSS_WAIT_UNIT;
          if (units_full) begin
            nxt_state   = AMSS_HOLD;
            nxt_cnt     = hold_len;
            nxt_timeout = 1'b1;
          end else begin
            nxt_units = units_ff + 8'h01;
          end
        end
      end
      AMSS_TAIL: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_last) begin
          nxt_state = AMSS_HOLD;
          nxt_cnt   = hold_len;
        end
      end
      AMSS_HOLD: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_last) begin
          nxt_state = AMSS_TURN;
          nxt_cnt   = turn_len;
        end
      end
      AMSS_TURN: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_last) begin
          nxt_state = AMSS_IDLE;
        end
      end
      default: begin
        nxt_state = AMSS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_ff     <= AMSS_IDLE;
      cnt_ff       <= `AMSS_CNT_RST;
      units_ff     <= `AMSS_CNT_RST;
      timeout_ff   <= 1'b0;
      wsync_ff     <= 3'h0;
      wait_seen_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      units_ff     <= nxt_units;
      timeout_ff   <= nxt_timeout;
      wsync_ff     <= {wsync_ff[1:0], i_wait_request_in};
      wait_seen_ff <= wait_now;
    end
  end

  // Address, bank and select latch at acceptance and stay put until the next one.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      write_ff <= 1'b0;
      addr_ff  <= '0;
      bank_ff  <= '0;
      cs_ff    <= `AMSS_CS_IDLE;
    end else if (take) begin
      write_ff <= i_req_write;
      addr_ff  <= i_req_addr;
      bank_ff  <= i_req_bank;
      cs_ff    <= i_req_cs_n;
    end
  end

  // Strobe pins are registered from the next state so each strobe edge is glitch free; select is decoded from the current state.
  wire nxt_strobe = (nxt_state == AMSS_STRB) || (nxt_state == AMSS_EXT) ||
                    (nxt_state == AMSS_TAIL);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= !(nxt_strobe && !write_ff);
      we_n_ff <= !(nxt_strobe && write_ff);
    end
  end

  assign o_req_ready           = take;
  assign o_busy                = (state_ff != AMSS_IDLE);
  assign o_wait_timeout        = timeout_ff;
  assign o_external_wait_units = units_ff;
  assign o_async_chip_select_n = cs_on ? cs_ff : `AMSS_CS_IDLE;
  assign o_output_enable_n     = oe_n_ff;
  assign o_write_enable_n      = we_n_ff;
  assign o_mem_address_out     = addr_ff;
  assign o_bank_select_out     = bank_ff;

  ////////////////////////////////////////////////////////////////////////////
  read_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == AMSS_IDLE && i_req_valid && !i_req_write && !i_extended_wait_enable &&
     i_read_setup_count == 8'h02 && i_read_strobe_count == 8'h03 &&
     i_read_hold_count == 8'h01) |=> (state_ff != AMSS_IDLE)[*6] ##1 state_ff == AMSS_TURN)
    else $error("read access length wrong");
  oe_width_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($fell(o_output_enable_n) && !i_extended_wait_enable && i_read_strobe_count == 8'h03)
    |-> !o_output_enable_n[*3] ##1 o_output_enable_n)
    else $error("read strobe width wrong");
  we_cs_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!o_write_enable_n) |-> (o_async_chip_select_n != `AMSS_CS_IDLE || cs_ff == `AMSS_CS_IDLE))
    else $error("write strobe outside select");
  ss_fall_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_select_strobe && $fell(o_output_enable_n)) |-> $past(o_async_chip_select_n) == `AMSS_CS_IDLE)
    else $error("select did not fall with strobe");
  addr_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == AMSS_HOLD) |-> $stable(o_mem_address_out) && $stable(o_bank_select_out))
    else $error("address moved in hold");
  tail_four_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == AMSS_EXT && nxt_state == AMSS_TAIL) |=> state_ff == AMSS_TAIL
    ##1 state_ff == AMSS_HOLD)
    else $error("strobe did not end four cycles after wait release");
  wait_cap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == AMSS_EXT) |-> units_ff <= i_max_external_wait || i_max_external_wait == 8'h00)
    else $error("wait units beyond maximum");
  turn_gap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == AMSS_HOLD && cnt_last && i_turnaround_count == 8'h02) |=>
    o_busy && !o_req_ready ##1 o_busy ##1 !o_busy)
    else $error("turnaround gap wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Pin and state checks for the write path, the select edges and the wait counting.
  write_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == AMSS_IDLE && i_req_valid && i_req_write && !i_extended_wait_enable &&
     i_write_setup_count == 8'h03 && i_write_strobe_count == 8'h02 &&
     i_write_hold_count == 8'h02) |=> (state_ff != AMSS_IDLE)[*7] ##1 state_ff == AMSS_TURN)
    else $error("write access length wrong");
  we_width_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($fell(o_write_enable_n) && !i_extended_wait_enable && i_write_strobe_count == 8'h02)
    |-> !o_write_enable_n[*2] ##1 o_write_enable_n)
    else $error("write strobe width wrong");
  cs_lead_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($fell(o_output_enable_n) && !i_select_strobe && i_read_setup_count == 8'h02) |->
    $past(o_async_chip_select_n, 2) != `AMSS_CS_IDLE &&
    $past(o_async_chip_select_n, 3) == `AMSS_CS_IDLE)
    else $error("select lead before read strobe wrong");
  cs_trail_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($rose(o_output_enable_n) && !i_select_strobe && i_read_hold_count == 8'h01) |->
    o_async_chip_select_n != `AMSS_CS_IDLE ##1 o_async_chip_select_n == `AMSS_CS_IDLE)
    else $error("select trail after read strobe wrong");
  ss_rise_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_select_strobe && $rose(o_write_enable_n)) |-> o_async_chip_select_n == `AMSS_CS_IDLE)
    else $error("select did not rise with write strobe");
  addr_setup_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_write_enable_n) |-> $stable(o_mem_address_out) && $stable(o_bank_select_out))
    else $error("address moved at write strobe");
  unit_step_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == AMSS_EXT && $changed(units_ff)) |-> units_ff == $past(units_ff) + 8'h01)
    else $error("wait units skipped");
  unit_start_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == AMSS_STRB && nxt_state == AMSS_EXT) |=>
    cnt_ff == `AMSS_WAIT_UNIT && units_ff == 8'h01)
    else $error("wait unit did not start at sixteen");
  timeout_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_wait_timeout) |-> state_ff == AMSS_HOLD &&
    $past(units_ff) >= $past(i_max_external_wait))
    else $error("timeout raised before maximum wait");
  idle_pins_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_busy |-> o_output_enable_n && o_write_enable_n &&
    o_async_chip_select_n == `AMSS_CS_IDLE)
    else $error("strobe or select active while idle");
endmodule
`default_nettype wire

/* hdl/amss_consts.svh */
// Timing and field constants for the asynchronous memory strobe sequencer.
// Assumes inclusion by the package and the design module only.
`ifndef AMSS_CONSTS_SVH
`define AMSS_CONSTS_SVH
`define AMSS_CNT_W        8
`define AMSS_ADDR_W       21
`define AMSS_BANK_W       2
`define AMSS_CS_W         4
`define AMSS_EWC_W        8
`define AMSS_WAIT_UNIT    8'h10
`define AMSS_WAIT_LEAD    3'h4
`define AMSS_SYNC_LAG     3'h3
`define AMSS_CS_IDLE      4'hf
`define AMSS_CNT_RST      8'h00
`endif

/* hdl/amss_pkg.sv */
// Types shared by the asynchronous memory strobe sequencer.
// Assumes the constants header is on the include path.
`include "amss_consts.svh"
package amss_pkg;
  typedef logic [`AMSS_CNT_W-1:0]  amss_cnt_t;
  typedef logic [`AMSS_ADDR_W-1:0] amss_addr_t;
  typedef logic [`AMSS_BANK_W-1:0] amss_bank_t;
  typedef logic [`AMSS_CS_W-1:0]   amss_cs_t;
  typedef enum logic [2:0] {
    AMSS_IDLE  = 3'b000,
    AMSS_SETUP = 3'b001,
    AMSS_STRB  = 3'b010,
    AMSS_EXT   = 3'b011,
    AMSS_TAIL  = 3'b100,
    AMSS_HOLD  = 3'b101,
    AMSS_TURN  = 3'b110
  } amss_state_e;
endpackage

/* verif/amss_mem_model.sv */
// Behavioural external memory that stretches strobes through its wait pin.
// Assumes the bench combines both active-low strobes into one.
`timescale 1ns/1ps
`default_nettype none
module amss_mem_model (
  input  wire logic i_clk,
  input  wire logic i_strobe_n,
  input  var  int   i_hold,
  output var  logic o_wait
);
  int n = 0;
  initial o_wait = 1'b0;
  // Wait rises in the first strobe cycle, long before the unstretched hold point.
  always @(negedge i_clk) begin
    if (i_strobe_n) begin
      n <= 0;
      o_wait <= 1'b0;
    end else begin
      n <= n + 1;
      o_wait <= (n < i_hold);
    end
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench: timed read and write accesses measured at the pins.
// Assumes the memory model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import amss_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, vld = 1'b0, wr = 1'b0, ew = 1'b0, ss = 1'b0, w_in;
  amss_addr_t addr = '0;
  amss_bank_t bank = '0;
  amss_cnt_t ta = 8'h01, su = 8'h01, st = 8'h01, ho = 8'h01, mx = 8'h01;
  logic rdy, busy, tmo, oe_n, we_n;
  amss_cnt_t units;
  amss_cs_t cs_n;
  amss_addr_t a_o;
  amss_bank_t b_o;
  int err_total = 0, checks_done = 0, hold = 0;
  // Columns: write, select-strobe, ext wait, setup, strobe, hold, turn, wait cycles, max.
  int tbl [0:6][0:8] = '{'{0,0,0,2,3,1,1,0,1}, '{1,0,0,3,2,2,2,0,1},
    '{0,1,0,2,3,1,1,0,1}, '{1,1,0,1,4,3,1,0,1}, '{0,0,1,2,8,1,1,0,8},
    '{0,0,1,2,8,1,1,40,8}, '{1,0,1,3,8,2,1,200,1}};
  always #5 i_clk = ~i_clk;
  amss_seq u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_req_valid(vld), .i_req_write(wr),
    .i_req_addr(addr), .i_req_bank(bank), .i_req_cs_n(4'he), .i_extended_wait_enable(ew),
    .i_select_strobe(ss), .i_turnaround_count(ta), .i_read_setup_count(su),
    .i_read_strobe_count(st), .i_read_hold_count(ho), .i_write_setup_count(su),
    .i_write_strobe_count(st), .i_write_hold_count(ho), .i_max_external_wait(mx),
    .i_wait_request_in(w_in), .o_req_ready(rdy), .o_busy(busy), .o_wait_timeout(tmo),
    .o_external_wait_units(units), .o_async_chip_select_n(cs_n), .o_output_enable_n(oe_n),
    .o_write_enable_n(we_n), .o_mem_address_out(a_o), .o_bank_select_out(b_o));
  amss_mem_model u_mem (.i_clk(i_clk), .i_strobe_n(oe_n & we_n), .i_hold(hold), .o_wait(w_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_n(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      err_total++;
      $display("BAD %0t cycle count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One access, started and measured at falling edges while the outputs are settled.
  task automatic run_case(input int k);
    int t, c0, c1, s0, s1, eu, r, sw;
    logic sb, csp, sbp, wp;
    begin
      {wr, ss, ew} = {tbl[k][0][0], tbl[k][1][0], tbl[k][2][0]};
      {su, st, ho, ta, mx} = {8'(tbl[k][3]), 8'(tbl[k][4]), 8'(tbl[k][5]),
                              8'(tbl[k][6]), 8'(tbl[k][8])};
      hold = tbl[k][7];
      addr = 21'h15a3c ^ 21'(k);
      bank = 2'(k);
      vld = 1'b1;
      @(posedge i_clk);
      for (t = 0; t < 50 && rdy !== 1'b1; t++) @(posedge i_clk);
      @(negedge i_clk);
      vld = 1'b0;
      {c0, c1, s0, s1, csp, sbp} = {-4, -4, -4, -4, 2'b11};
      r = -4;
      wp = 1'b0;
      for (t = 0; t < 600 && busy === 1'b1; t++) begin
        sb = wr ? we_n : oe_n;
        if (csp && cs_n !== 4'hf) c0 = t;
        if (!csp && cs_n === 4'hf) c1 = t;
        if (sbp && !sb) s0 = t;
        if (!sbp && sb) s1 = t;
        if (!sb && wp && w_in === 1'b0) r = t;
        wp = (w_in === 1'b1);
        chk_v({b_o, a_o}, {bank, addr});
        chk_v(wr ? oe_n : we_n, 1'b1);
        csp = (cs_n === 4'hf);
        sbp = sb;
        @(negedge i_clk);
      end
      // A released wait ends the strobe four cycles after the pin drops; units round up.
      sw = (hold == 40) ? r + 4 - s0 : tbl[k][4] + 16 * ((hold >= 200) ? tbl[k][8] : 0);
      eu = (hold == 0) ? 0 : ((hold >= 200) ? tbl[k][8] : (sw - tbl[k][4] + 15) / 16);
      if (hold == 40) chk_v(units != 8'h00, 1'b1);
      if (hold == 40) chk_n(s1 - r, 4);
      chk_v(units, 8'(eu));
      chk_v(tmo, hold >= 200);
      chk_n(s1 - s0, sw);
      chk_n(s0 - c0, ss ? 0 : tbl[k][3]);
      chk_n(c1 - s1, ss ? 0 : tbl[k][5]);
      if (!ss) chk_n(c1 - c0, tbl[k][3] + sw + tbl[k][5]);
      if (!ss) chk_n(t - c1, tbl[k][6]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge i_clk);
    i_nrst = 1'b1;
    chk_v({oe_n, we_n, cs_n, a_o}, {6'h3f, 21'h0});
    for (int k = 0; k < 7; k++) run_case(k);
    end_of_test();
  end
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
